// ---- src/mac_table_pkg.sv ----
package mac_table_pkg;

    // ----------------------------------------------------------------
    // Table geometry
    // ----------------------------------------------------------------
    localparam int BUCKET_W = 10;
    localparam int BIN_W = 2;
    localparam int N_BINS = 4;
    localparam int N_ENTRIES = 4096;
    localparam int PORT_W = 3;
    localparam int VID_W = 12;
    localparam int MAC_W = 48;
    localparam int KEY_W = 60;
    localparam logic [BUCKET_W-1:0] LAST_BUCKET = 10'h3ff;

    // ----------------------------------------------------------------
    // Hash and address classes
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam int GROUP_BIT = 40;
    localparam logic [39:0] RSVD_PREFIX = 40'h0180c20000;
    localparam logic [7:0] RSVD_LAST = 8'h2f;

    // ----------------------------------------------------------------
    // Register offsets, fields and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAC_LO = 8'h04;
    localparam logic [7:0] REG_MAC_HI = 8'h08;
    localparam logic [7:0] REG_ENTRY = 8'h0c;
    localparam logic [7:0] REG_CMD = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam int CTRL_VLAN_BIT = 0;
    localparam int CTRL_RSVD_LEARN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam int ENTRY_VID_LSB = 0;
    localparam int ENTRY_PORT_LSB = 12;
    localparam int ENTRY_STATIC_BIT = 16;
    localparam int ENTRY_VALID_BIT = 17;
    localparam int ENTRY_AGE_BIT = 18;
    localparam int ENTRY_BIN_LSB = 20;
    localparam int ENTRY_W = 22;
    localparam logic [ENTRY_W-1:0] ENTRY_RESET = 22'h0;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_AGE_BIT = 1;
    localparam int STATUS_SW_BIT = 0;
    localparam int STATUS_AGE_BIT = 1;
    localparam int STATUS_CNT_LSB = 16;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic is_static;
        logic age;
        logic [VID_W-1:0] vid;
        logic [PORT_W-1:0] port;
        logic [MAC_W-1:0] mac;
    } entry_t;

    typedef struct packed {
        logic [MAC_W-1:0] da;
        logic [MAC_W-1:0] sa;
        logic [VID_W-1:0] vid;
    } rx_hdr_t;

    typedef struct packed {
        logic rx_err;
        logic len_ok;
        logic sa_in_vlan;
        logic [PORT_W-1:0] src_port;
    } rx_end_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD_LO = 2'b01,
        ST_RD_HI = 2'b10,
        ST_DECIDE = 2'b11
    } state_t;

    typedef enum logic [1:0] {
        OP_LOOKUP = 2'b00,
        OP_LEARN = 2'b01,
        OP_AGE = 2'b10,
        OP_WRITE = 2'b11
    } op_t;

endpackage

// ---- src/mac_hash.sv ----
`timescale 1ns/1ps
`default_nettype none

module mac_hash
    import mac_table_pkg::*;
(
    input wire logic [MAC_W-1:0] mac, // Address part of key
    input wire logic [VID_W-1:0] vid, // VLAN part of key
    input wire logic vlan_en, // Fold VLAN into key
    output logic [15:0] crc // Hash value
);

    // ----------------------------------------------------------------
    // Bitwise CRC, MSB first, zero start
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_key(input logic [KEY_W-1:0] key, input logic use_vid);
        logic [15:0] c;
        logic fb;
        c = CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < KEY_W; i++) begin
            if (use_vid || i < MAC_W) begin
                fb = c[15] ^ key[KEY_W-1-i];
                c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
            end
        end
        return c;
    endfunction

    // Key is address then VLAN
    assign crc = crc_key({mac, vid}, vlan_en);

endmodule

`default_nettype wire

// ---- src/mac_address_table_learning.sv ----
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module mac_address_table_learning
    import mac_table_pkg::*;
(
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic hdr_valid, // Header of a frame seen
    input wire rx_hdr_t hdr, // Destination, source, VLAN
    input wire logic eof_valid, // Frame fully received
    input wire rx_end_t eof_info, // End of frame status
    output logic lookup_done, // Destination result pulse
    output logic lookup_hit, // Destination found
    output logic [PORT_W-1:0] lookup_port, // Destination port
    output logic learn_done, // Learn attempt finished
    output logic learn_ok, // New entry created
    input wire logic [7:0] addr, // Register address
    input wire logic [31:0] wdata, // Register write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata // Read data, one cycle later
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    entry_t mem_reg [N_ENTRIES];
    entry_t bins_reg [N_BINS];
    entry_t new_bins [N_BINS];
    state_t state_reg;
    state_t state_next;
    op_t op_reg;
    op_t op_next;
    logic [1:0] ctrl_reg;
    logic [31:0] mac_lo_reg;
    logic [15:0] mac_hi_reg;
    logic [ENTRY_W-1:0] entry_reg;
    logic sw_pend_reg;
    logic age_pend_reg;
    logic [BUCKET_W-1:0] age_bkt_reg;
    rx_hdr_t hdr_reg;
    logic lookup_pend_reg;
    logic learn_pend_reg;
    logic [MAC_W-1:0] learn_mac_reg;
    logic [VID_W-1:0] learn_vid_reg;
    logic [PORT_W-1:0] learn_port_reg;
    logic [MAC_W-1:0] key_mac_reg;
    logic [VID_W-1:0] key_vid_reg;
    logic [PORT_W-1:0] key_port_reg;
    logic [15:0] learn_cnt_reg;
    logic [11:0] learn_addr_reg;
    logic lookup_done_reg;
    logic lookup_hit_reg;
    logic [PORT_W-1:0] lookup_port_reg;
    logic learn_done_reg;
    logic learn_ok_reg;
    logic [31:0] rdata_reg;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    function automatic logic [BIN_W-1:0] lowest_set(input logic [N_BINS-1:0] v);
        logic [BIN_W-1:0] r;
        r = 2'h0;
        for (int i = N_BINS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = BIN_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] slot(input logic [BUCKET_W-1:0] b, input logic [BIN_W-1:0] n);
        return {b, n};
    endfunction

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    wire logic vlan_en = ctrl_reg[CTRL_VLAN_BIT];
    wire logic rsvd_learn = ctrl_reg[CTRL_RSVD_LEARN_BIT];
    wire logic wr_ctrl = wr && addr == REG_CTRL;
    wire logic wr_mac_lo = wr && addr == REG_MAC_LO;
    wire logic wr_mac_hi = wr && addr == REG_MAC_HI;
    wire logic wr_entry = wr && addr == REG_ENTRY;
    wire logic wr_cmd = wr && addr == REG_CMD;
    wire logic cmd_write = wr_cmd && wdata[CMD_WRITE_BIT];
    wire logic cmd_age = wr_cmd && wdata[CMD_AGE_BIT];
    wire logic [31:0] status_w = {learn_cnt_reg, 14'h0000, age_pend_reg, sw_pend_reg};
    wire logic [31:0] rd_mux = (addr == REG_CTRL) ? {30'h0, ctrl_reg} :
                               (addr == REG_MAC_LO) ? mac_lo_reg :
                               (addr == REG_MAC_HI) ? {16'h0000, mac_hi_reg} :
                               (addr == REG_ENTRY) ? {10'h000, entry_reg} :
                               (addr == REG_STATUS) ? status_w : 32'h0;

    // ----------------------------------------------------------------
    // Learn qualification at end of frame
    // ----------------------------------------------------------------
    wire logic da_rsvd = hdr_reg.da[47:8] == RSVD_PREFIX && hdr_reg.da[7:0] <= RSVD_LAST;
    wire logic learn_qual = !eof_info.rx_err
                          && eof_info.len_ok
                          && !hdr_reg.sa[GROUP_BIT]
                          && (!vlan_en || eof_info.sa_in_vlan)
                          && (rsvd_learn || !da_rsvd);

    // ----------------------------------------------------------------
    // Arbitration of table engine
    // ----------------------------------------------------------------
    wire logic idle = state_reg == ST_IDLE;
    wire logic grant_sw = idle && sw_pend_reg;
    wire logic grant_lookup = idle && !sw_pend_reg && lookup_pend_reg;
    wire logic grant_learn = idle && !sw_pend_reg && !lookup_pend_reg && learn_pend_reg;
    wire logic grant_age = idle && !sw_pend_reg && !lookup_pend_reg && !learn_pend_reg && age_pend_reg;
    wire logic grant_any = grant_sw || grant_lookup || grant_learn || grant_age;
    wire logic [MAC_W-1:0] sw_mac = {mac_hi_reg, mac_lo_reg};
    wire logic [MAC_W-1:0] key_mac_next = grant_sw ? sw_mac : grant_lookup ? hdr_reg.da : learn_mac_reg;
    wire logic [VID_W-1:0] key_vid_next = grant_sw ? entry_reg[ENTRY_VID_LSB +: VID_W] :
                                          grant_lookup ? hdr_reg.vid : learn_vid_reg;

    // Next operation and state
    always_comb begin
        op_next = op_reg;
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (grant_sw) begin
                    op_next = OP_WRITE;
                    state_next = ST_DECIDE;
                end else if (grant_any) begin
                    op_next = grant_lookup ? OP_LOOKUP : grant_learn ? OP_LEARN : OP_AGE;
                    state_next = ST_RD_LO;
                end
            end
            ST_RD_LO: state_next = ST_RD_HI;
            ST_RD_HI: state_next = ST_DECIDE;
            ST_DECIDE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Bucket index and pair read
    // ----------------------------------------------------------------
    logic [15:0] crc_w;

    mac_hash u_hash (
        .mac(key_mac_reg),
        .vid(key_vid_reg),
        .vlan_en(vlan_en),
        .crc(crc_w)
    );

    wire logic [BUCKET_W-1:0] bucket = (op_reg == OP_AGE) ? age_bkt_reg : crc_w[BUCKET_W-1:0];
    wire logic rd_half = state_reg == ST_RD_HI;
    wire entry_t rd_a = mem_reg[slot(bucket, {rd_half, 1'b0})];
    wire entry_t rd_b = mem_reg[slot(bucket, {rd_half, 1'b1})];

    // ----------------------------------------------------------------
    // Match and free bin search over all four bins
    // ----------------------------------------------------------------
    logic [N_BINS-1:0] match;
    logic [N_BINS-1:0] free;

    always_comb begin
        for (int i = 0; i < N_BINS; i++) begin
            match[i] = bins_reg[i].valid && bins_reg[i].mac == key_mac_reg
                       && (!vlan_en || bins_reg[i].vid == key_vid_reg);
            free[i] = !bins_reg[i].valid;
        end
    end

    wire logic any_hit = |match;
    wire logic [BIN_W-1:0] hit_bin = lowest_set(match);
    wire logic any_free = |free;
    wire logic [BIN_W-1:0] free_bin = lowest_set(free);
    wire logic [PORT_W-1:0] hit_port = bins_reg[hit_bin].port;

    // New bucket contents for learn and aging
    always_comb begin
        for (int i = 0; i < N_BINS; i++) begin
            new_bins[i] = bins_reg[i];
            if (op_reg == OP_LEARN) begin
                if (any_hit && match[i] && !bins_reg[i].is_static) begin
                    new_bins[i].age = 1'b1;
                end else if (!any_hit && any_free && free_bin == BIN_W'(i)) begin
                    new_bins[i].valid = 1'b1;
                    new_bins[i].age = 1'b1;
                    new_bins[i].is_static = 1'b0;
                    new_bins[i].vid = key_vid_reg;
                    new_bins[i].port = key_port_reg;
                    new_bins[i].mac = key_mac_reg;
                end
            end else if (op_reg == OP_AGE && bins_reg[i].valid && !bins_reg[i].is_static) begin
                if (bins_reg[i].age) begin
                    new_bins[i].age = 1'b0;
                end else begin
                    new_bins[i].valid = 1'b0;
                end
            end
        end
    end

    wire logic decide = state_reg == ST_DECIDE;
    wire logic bucket_wr = decide && (op_reg == OP_LEARN || op_reg == OP_AGE);
    wire entry_t sw_entry = {entry_reg[ENTRY_VALID_BIT], entry_reg[ENTRY_STATIC_BIT], entry_reg[ENTRY_AGE_BIT],
                             entry_reg[ENTRY_VID_LSB +: VID_W], entry_reg[ENTRY_PORT_LSB +: PORT_W], sw_mac};
    wire logic [BIN_W-1:0] sw_bin = entry_reg[ENTRY_BIN_LSB +: BIN_W];

    // ----------------------------------------------------------------
    // Table storage
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_ENTRIES; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (bucket_wr) begin
            for (int i = 0; i < N_BINS; i++) begin
                mem_reg[slot(bucket, BIN_W'(i))] <= new_bins[i];
            end
        end else if (decide && op_reg == OP_WRITE) begin
            mem_reg[slot(bucket, sw_bin)] <= sw_entry;
        end
    end

    // Fetched bucket, two bins per cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N_BINS; i++) begin
                bins_reg[i] <= '0;
            end
        end else if (state_reg == ST_RD_LO || state_reg == ST_RD_HI) begin
            bins_reg[{rd_half, 1'b0}] <= rd_a;
            bins_reg[{rd_half, 1'b1}] <= rd_b;
        end
    end

    // ----------------------------------------------------------------
    // Engine, pending requests and frame capture
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            op_reg <= OP_LOOKUP;
            key_mac_reg <= '0;
            key_vid_reg <= '0;
            key_port_reg <= '0;
            hdr_reg <= '0;
            lookup_pend_reg <= 1'b0;
            learn_pend_reg <= 1'b0;
            learn_mac_reg <= '0;
            learn_vid_reg <= '0;
            learn_port_reg <= '0;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            if (grant_any) begin
                key_mac_reg <= key_mac_next;
                key_vid_reg <= key_vid_next;
                key_port_reg <= learn_port_reg;
            end
            if (hdr_valid) begin
                hdr_reg <= hdr;
            end
            lookup_pend_reg <= hdr_valid || (lookup_pend_reg && !grant_lookup);
            if (eof_valid) begin
                learn_mac_reg <= hdr_reg.sa;
                learn_vid_reg <= hdr_reg.vid;
                learn_port_reg <= eof_info.src_port;
                learn_pend_reg <= learn_qual;
            end else if (grant_learn) begin
                learn_pend_reg <= 1'b0;
            end
        end
    end

    // Software registers and aging sweep
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            mac_lo_reg <= '0;
            mac_hi_reg <= '0;
            entry_reg <= ENTRY_RESET;
            sw_pend_reg <= 1'b0;
            age_pend_reg <= 1'b0;
            age_bkt_reg <= '0;
        end else begin
            if (wr_ctrl) ctrl_reg <= wdata[1:0];
            if (wr_mac_lo) mac_lo_reg <= wdata;
            if (wr_mac_hi) mac_hi_reg <= wdata[15:0];
            if (wr_entry) entry_reg <= wdata[ENTRY_W-1:0];
            sw_pend_reg <= cmd_write || (sw_pend_reg && !grant_sw);
            if (cmd_age) begin
                age_pend_reg <= 1'b1;
                age_bkt_reg <= '0;
            end else if (decide && op_reg == OP_AGE) begin
                age_pend_reg <= age_bkt_reg != LAST_BUCKET;
                age_bkt_reg <= age_bkt_reg + 10'h001;
            end
        end
    end

    // Result outputs and read data
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lookup_done_reg <= 1'b0;
            lookup_hit_reg <= 1'b0;
            lookup_port_reg <= '0;
            learn_done_reg <= 1'b0;
            learn_ok_reg <= 1'b0;
            learn_cnt_reg <= '0;
            learn_addr_reg <= '0;
            rdata_reg <= '0;
        end else begin
            lookup_done_reg <= decide && op_reg == OP_LOOKUP;
            if (decide && op_reg == OP_LOOKUP) begin
                lookup_hit_reg <= any_hit;
                lookup_port_reg <= any_hit ? hit_port : '0;
            end
            learn_done_reg <= decide && op_reg == OP_LEARN;
            learn_ok_reg <= decide && op_reg == OP_LEARN && !any_hit && any_free;
            if (decide && op_reg == OP_LEARN && !any_hit && any_free) begin
                learn_cnt_reg <= learn_cnt_reg + 16'h0001;
                learn_addr_reg <= slot(bucket, free_bin);
            end
            rdata_reg <= rd ? rd_mux : 32'h0;
        end
    end

    assign lookup_done = lookup_done_reg;
    assign lookup_hit = lookup_hit_reg;
    assign lookup_port = lookup_port_reg;
    assign learn_done = learn_done_reg;
    assign learn_ok = learn_ok_reg;
    assign rdata = rdata_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    pair_fetch_a: assert property (state_reg == ST_RD_LO |=> state_reg == ST_RD_HI ##1 state_reg == ST_DECIDE)
        else $error("bucket fetch not two pair reads");
    bucket_index_a: assert property (op_reg != OP_AGE |-> bucket == crc_w[9:0])
        else $error("bucket not low hash bits");
    lookup_bound_a: assert property ($rose(lookup_pend_reg) && !sw_pend_reg |-> ##[1:16] lookup_done)
        else $error("lookup not answered in time");
    err_no_learn_a: assert property (eof_valid && eof_info.rx_err |=> !learn_pend_reg)
        else $error("errored frame queued for learning");
    group_no_learn_a: assert property (eof_valid && hdr_reg.sa[GROUP_BIT] |=> !learn_pend_reg)
        else $error("group source queued for learning");
    full_no_learn_a: assert property (decide && op_reg == OP_LEARN && !any_free |=> learn_done && !learn_ok)
        else $error("learned into full bucket");
    learned_flags_a: assert property (learn_ok |-> mem_reg[learn_addr_reg].valid && mem_reg[learn_addr_reg].age
                                      && !mem_reg[learn_addr_reg].is_static)
        else $error("learned entry flags wrong");
    hit_port_a: assert property (decide && op_reg == OP_LOOKUP && any_hit
                                 |=> lookup_hit && lookup_port == $past(hit_port))
        else $error("hit port not from matching bin");
    static_keep_a: assert property (decide && op_reg == OP_AGE && bins_reg[0].valid && bins_reg[0].is_static
                                    |=> mem_reg[slot($past(bucket), 2'h0)].valid)
        else $error("static entry aged out");

endmodule

`default_nettype wire

// ---- verification/rx_path_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rx_path_model
    import mac_table_pkg::*;
(
    input wire logic ref_clk, // Core clock
    output logic hdr_valid = 1'b0, // Header strobe
    output rx_hdr_t hdr = '0, // Frame header
    output logic eof_valid = 1'b0, // Frame end strobe
    output rx_end_t eof_info = '0 // Frame end status
);
    // Header for one cycle, then scrambled
    task automatic send_hdr(input rx_hdr_t h);
        @(posedge ref_clk);
        hdr_valid <= 1'b1;
        hdr <= h;
        @(posedge ref_clk);
        hdr_valid <= 1'b0;
        hdr <= ~h;
    endtask
    // End status for one cycle, then scrambled
    task automatic send_eof(input rx_end_t e);
        @(posedge ref_clk);
        eof_valid <= 1'b1;
        eof_info <= e;
        @(posedge ref_clk);
        eof_valid <= 1'b0;
        eof_info <= ~e;
    endtask
endmodule
`default_nettype wire

// ---- verification/mac_address_table_learning_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module mac_address_table_learning_test;
    import mac_table_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic hdr_valid, eof_valid, lookup_done, lookup_hit, learn_done, learn_ok;
    logic [PORT_W-1:0] lookup_port;
    logic [31:0] rdata;
    rx_hdr_t hdr;
    rx_end_t eof_info;
    int failures = 0;
    int comparisons = 0;
    localparam logic [47:0] DA = 48'h0a00_0000_0009;
    localparam logic [47:0] RSV = 48'h0180_c200_0005;
    localparam logic [47:0] MA = 48'h0011_2233_4455;
    localparam logic [47:0] MB = 48'h0066_7788_99aa;
    localparam logic [47:0] MC = 48'h00bb_ccdd_eeff;
    localparam logic [47:0] MG = 48'h0100_0000_0042;
    localparam logic [47:0] MM = 48'h0100_5e00_0001;
    // Clock
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    rx_path_model m (.ref_clk(ref_clk), .hdr_valid(hdr_valid), .hdr(hdr), .eof_valid(eof_valid),
        .eof_info(eof_info));
    mac_address_table_learning dut (.ref_clk(ref_clk), .rst_n(rst_n), .hdr_valid(hdr_valid), .hdr(hdr),
        .eof_valid(eof_valid), .eof_info(eof_info), .lookup_done(lookup_done), .lookup_hit(lookup_hit),
        .lookup_port(lookup_port), .learn_done(learn_done), .learn_ok(learn_ok), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    task automatic check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            failures++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    // Whole frame, then watch for the learn pulse
    task automatic frame(input logic [47:0] da, sa, input logic [11:0] vid, input rx_end_t e, input logic dn, ok);
        logic seen = 1'b0;
        logic got = 1'b0;
        m.send_hdr({da, sa, vid});
        repeat (5) @(posedge ref_clk);
        m.send_eof(e);
        repeat (12) begin
            @(negedge ref_clk);
            if (learn_done === 1'b1) begin
                seen = 1'b1;
                got = learn_ok;
            end
        end
        check(seen === dn && got === ok, "learn outcome");
    endtask
    task automatic look(input logic [47:0] da, input logic [11:0] vid, input logic hit, input logic [2:0] p);
        m.send_hdr({da, 48'h0200_0000_0001, vid});
        repeat (16) begin
            @(negedge ref_clk);
            if (lookup_done === 1'b1) break;
        end
        check(lookup_done === 1'b1 && lookup_hit === hit && lookup_port === p, "lookup result");
    endtask
    task automatic age_sweep();
        logic [31:0] s;
        reg_wr(REG_CMD, 32'h2);
        repeat (8000) begin
            reg_rd(REG_STATUS, s);
            if (s[STATUS_AGE_BIT] === 1'b0) break;
        end
        check(s[STATUS_AGE_BIT] === 1'b0, "sweep end");
    endtask
    task automatic final_report();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #80000;
        failures++;
        final_report();
    end
    // Test sequence
    initial begin
        logic [31:0] r;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        frame(DA, MA, 12'h0, 6'b010011, 1'b1, 1'b1);
        look(MA, 12'h0, 1'b1, 3'h3);
        frame(DA, MA, 12'h0, 6'b010011, 1'b1, 1'b0);
        frame(DA, MB, 12'h0, 6'b110011, 1'b0, 1'b0);
        frame(DA, MB, 12'h0, 6'b000011, 1'b0, 1'b0);
        frame(DA, MG, 12'h0, 6'b010011, 1'b0, 1'b0);
        frame(RSV, MB, 12'h0, 6'b010010, 1'b0, 1'b0);
        look(MB, 12'h0, 1'b0, 3'h0);
        reg_wr(REG_CTRL, 32'h2);
        frame(RSV, MB, 12'h0, 6'b010010, 1'b1, 1'b1);
        reg_wr(REG_CTRL, 32'h1);
        frame(DA, MC, 12'h5, 6'b010001, 1'b0, 1'b0);
        frame(DA, MC, 12'h5, 6'b011001, 1'b1, 1'b1);
        look(MC, 12'h5, 1'b1, 3'h1);
        look(MC, 12'h6, 1'b0, 3'h0);
        reg_rd(REG_STATUS, r);
        check(r[31:16] === 16'h3, "learn count");
        reg_rd(8'hfc, r);
        check(r === 32'h0, "unmapped read");
        reg_wr(REG_CTRL, 32'h0);
        reg_wr(REG_MAC_LO, MM[31:0]);
        reg_wr(REG_MAC_HI, {16'h0, MM[47:32]});
        reg_wr(REG_ENTRY, 32'h0003_5000);
        reg_wr(REG_CMD, 32'h1);
        repeat (16) @(posedge ref_clk);
        look(MM, 12'h0, 1'b1, 3'h5);
        age_sweep();
        age_sweep();
        look(MA, 12'h0, 1'b0, 3'h0);
        look(MM, 12'h0, 1'b1, 3'h5);
        // Keys that are multiples of the hash polynomial all fall into bucket 0
        frame(DA, 48'h0000_0001_1021, 12'h0, 6'b010000, 1'b1, 1'b1);
        frame(DA, 48'h0000_0002_2042, 12'h0, 6'b010001, 1'b1, 1'b1);
        frame(DA, 48'h0000_0003_3063, 12'h0, 6'b010010, 1'b1, 1'b1);
        frame(DA, 48'h0000_0004_4084, 12'h0, 6'b010100, 1'b1, 1'b1);
        frame(DA, 48'h0000_0008_8108, 12'h0, 6'b010101, 1'b1, 1'b0);
        look(48'h0000_0004_4084, 12'h0, 1'b1, 3'h4);
        look(48'h0000_0008_8108, 12'h0, 1'b0, 3'h0);
        reg_rd(REG_STATUS, r);
        check(r[31:16] === 16'h7, "learn count after full bucket");
        final_report();
    end
endmodule
`default_nettype wire
